/* rtl/sps_map.svh */
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
// Local command codes carried in the seventh command-block word.
`define SPS_CMD_INIT 16'h10CC
`define SPS_CMD_FLUSH 16'h10CE
`define SPS_CMD_STATUS 16'h10CF
`define SPS_CMD_RTS 16'h10D0
// Port status word bit positions.
`define SPS_BIT_RD_ACT 15
`define SPS_BIT_RD_OK 14
`define SPS_BIT_RD_TMO 13
`define SPS_BIT_WR_ACT 12
`define SPS_BIT_WR_OK 11
`define SPS_BIT_WR_TMO 10
`define SPS_BIT_CHARS 9
`define SPS_BIT_OVR 8
`define SPS_BIT_FRM 7
`define SPS_BIT_PAR 6
`define SPS_BIT_CTS 5
// Port control word bit that carries the commanded request-to-send.
`define SPS_BIT_CTL_RTS 15
// Completion codes written to the requester's status word.
`define SPS_DONE_OK 16'h0001
`define SPS_DONE_BAD 16'h0002
// Reset values.
`define SPS_RST_WORD 16'h0000
`define SPS_RST_RTS 1'b0
`endif

/* rtl/sps_pkg.sv */
package sps_pkg;
    // Duplex modes of the two-wire capable port.
    typedef enum logic [1:0] {
        SPS_DPX_PTP = 2'b00,
        SPS_DPX_2W = 2'b01,
        SPS_DPX_4W = 2'b10
    } sps_dpx_type;
    // A local command as lifted from the command block.
    typedef struct packed {
        logic [15:0] code;
        logic [15:0] word8;
        logic [15:0] word9;
        logic [15:0] stat_type;
        logic [15:0] stat_off;
    } sps_cmd_type;
    // Two-word port status deposit for a status request.
    typedef struct packed {
        logic valid;
        logic [15:0] status;
        logic [15:0] count;
        logic [15:0] mem_type;
        logic [15:0] mem_off;
    } sps_reply_type;
    // Completion write to the requester's status word.
    typedef struct packed {
        logic valid;
        logic [15:0] mem_type;
        logic [15:0] mem_off;
        logic [15:0] code;
    } sps_done_type;
endpackage : sps_pkg

/* rtl/sps_ctrl.sv */
`timescale 1ns/100ps
`include "sps_map.svh"
// Function
// (R01) Code 4302 in word seven requests a receive buffer flush.
// (R02) Flush discards every unread received character; buffer ends empty.
// (R03) Code 4303 in word seven requests port status.
// (R04) Requester gives deposit memory type and offset in words eight, nine.
// (R05) Status reply is the status word, then the unread character count.
// (R06) read_active sets on read start, clears on finish, timeout, cancel.
// (R07) read_done_ok sets on read success, clears on new read.
// (R08) read_timed_out sets on receive timeout, clears on new read.
// (R09) write_active sets on write start, clears on finish, timeout, cancel.
// (R10) write_done_ok sets on write success, clears on new write.
// (R11) write_timed_out sets on transmit timeout, clears on new write.
// (R12) rx_chars_waiting is one exactly while unread characters are buffered.
// (R13) overrun_flag is sticky; a status request clears it.
// (R14) A full buffer drops incoming characters and sets overrun_flag.
// (R15) frame_err is sticky; a status request clears it.
// (R16) parity_err is sticky; a status request clears it.
// (R17) clear_to_send_seen follows CTS, or reads one without a CTS input.
// (R18) Status word bits four to zero read zero.
// (R19) Read and write conditions are kept independently.
// (R20) Code 4304 forces RTS; control word sits in word eight.
// (R21) Control word bit 15 sets the commanded RTS state.
// (R22) Requester writes zeros in control word bits 0 to 14.
// (R23) On the two-wire port, line RTS is gated by the driver enable.
// (R24) Two- and four-wire modes enable the driver only while sending.
// (R25) Point-to-point mode keeps the driver enabled permanently.
// (R26) The initialize command drives commanded RTS inactive.
// (R27) Each local command ends with a completion write to the requester.
module sps_ctrl import sps_pkg::*; #(
    parameter int DEPTH = 2048
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Local command port.
    input wire logic cmd_valid_i,
    input wire sps_cmd_type cmd_i,
    output logic cmd_ready_o,
    output sps_reply_type reply_o,
    output sps_done_type done_o,
    // Transfer progress events from the read and write engines.
    input wire logic rd_start_i,
    input wire logic rd_ok_i,
    input wire logic rd_tmo_i,
    input wire logic rd_cancel_i,
    input wire logic wr_start_i,
    input wire logic wr_ok_i,
    input wire logic wr_tmo_i,
    input wire logic wr_cancel_i,
    // Receiver side.
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_overrun_i,
    input wire logic rx_frame_err_i,
    input wire logic rx_parity_err_i,
    input wire logic rd_take_i,
    output logic [7:0] rd_data_o,
    output logic rd_data_valid_o,
    // Line control.
    input wire logic cts_i,
    input wire logic cts_present_i,
    input wire logic port_is_485_i,
    input wire sps_dpx_type duplex_i,
    input wire logic tx_sending_i,
    output logic tx_drv_en_o,
    output logic rts_line_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } sps_state_type;

    ////////////////////////////////////////////////////////////////////////
    // Command sequencing.
    sps_state_type state_q, state_d;
    sps_cmd_type cmd_q, cmd_d;
    logic ready_q, ready_d;
    logic do_flush, do_status, do_rts, do_init;

    // Decode of the command under execution.
    assign do_flush = (state_q == ST_EXEC) && (cmd_q.code == `SPS_CMD_FLUSH);
    assign do_status = (state_q == ST_EXEC) &&
                       (cmd_q.code == `SPS_CMD_STATUS);
    assign do_rts = (state_q == ST_EXEC) && (cmd_q.code == `SPS_CMD_RTS);
    assign do_init = (state_q == ST_EXEC) && (cmd_q.code == `SPS_CMD_INIT);

    // A command is latched in idle and acted on in the following cycle.
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        ready_d = ready_q;
        unique case (state_q)
            ST_IDLE: begin
                if (cmd_valid_i && ready_q) begin
                    cmd_d = cmd_i;
                    state_d = ST_EXEC;
                    ready_d = 1'b0;
                end
            end
            ST_EXEC: begin
                state_d = ST_IDLE;
                ready_d = 1'b1;
            end
            default: begin
                state_d = ST_IDLE;
                ready_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_IDLE;
            cmd_q <= '0;
            ready_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            ready_q <= ready_d;
        end
    end
    assign cmd_ready_o = ready_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer.
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic full, push, pop, flush, buf_ovr;
    logic [7:0] rdat_q, rdat_d;
    logic rval_q, rval_d;

    assign full = (cnt_q == CW'(DEPTH));
    assign flush = do_flush || do_init; // [R01] [R02]
    // A flush in the same cycle also swallows an arriving character.
    assign push = rx_valid_i && !full && !flush;
    assign pop = rd_take_i && (cnt_q != '0) && !flush;
    assign buf_ovr = rx_valid_i && full && !flush; // [R14]

    // Pointers wrap explicitly so a non power of two depth also works.
    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        rdat_d = rdat_q;
        rval_d = pop;
        if (flush) begin
            wr_d = '0; // [R02]
            rd_d = '0;
            cnt_d = '0;
        end else begin
            if (push) begin
                wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rdat_d = mem[rd_q];
                rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_d = cnt_q + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            rdat_q <= 8'h00;
            rval_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            rdat_q <= rdat_d;
            rval_q <= rval_d;
        end
    end

    // Storage carries no reset; stale bytes are never read past the count.
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_q] <= rx_data_i;
        end
    end
    assign rd_data_o = rdat_q;
    assign rd_data_valid_o = rval_q;

    ////////////////////////////////////////////////////////////////////////
    // Port status flags.
    logic rda_q, rda_d, rdo_q, rdo_d, rdt_q, rdt_d;
    logic wra_q, wra_d, wro_q, wro_d, wrt_q, wrt_d;
    logic ovr_q, ovr_d, frm_q, frm_d, par_q, par_d;
    logic [15:0] stat_word;

    // Read and write flags are separate so both outcomes can coexist.
    // A new start wins over an end arriving in the same cycle. [R19]
    always_comb begin
        rda_d = rda_q;
        rdo_d = rdo_q;
        rdt_d = rdt_q;
        wra_d = wra_q;
        wro_d = wro_q;
        wrt_d = wrt_q;
        if (rd_start_i) begin
            rda_d = 1'b1; // [R06]
            rdo_d = 1'b0; // [R07]
            rdt_d = 1'b0; // [R08]
        end else begin
            if (rd_ok_i || rd_tmo_i || rd_cancel_i) begin
                rda_d = 1'b0; // [R06]
            end
            if (rd_ok_i) begin
                rdo_d = 1'b1; // [R07]
            end
            if (rd_tmo_i) begin
                rdt_d = 1'b1; // [R08]
            end
        end
        if (wr_start_i) begin
            wra_d = 1'b1; // [R09]
            wro_d = 1'b0; // [R10]
            wrt_d = 1'b0; // [R11]
        end else begin
            if (wr_ok_i || wr_tmo_i || wr_cancel_i) begin
                wra_d = 1'b0; // [R09]
            end
            if (wr_ok_i) begin
                wro_d = 1'b1; // [R10]
            end
            if (wr_tmo_i) begin
                wrt_d = 1'b1; // [R11]
            end
        end
        // Sticky errors: a new event in the clearing cycle still sets.
        ovr_d = (ovr_q && !do_status) || buf_ovr || rx_overrun_i; // [R13]
        frm_d = (frm_q && !do_status) || rx_frame_err_i; // [R15]
        par_d = (par_q && !do_status) || rx_parity_err_i; // [R16]
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {rda_q, rdo_q, rdt_q, wra_q, wro_q, wrt_q} <= 6'h00;
            {ovr_q, frm_q, par_q} <= 3'h0;
        end else begin
            {rda_q, rdo_q, rdt_q} <= {rda_d, rdo_d, rdt_d};
            {wra_q, wro_q, wrt_q} <= {wra_d, wro_d, wrt_d};
            {ovr_q, frm_q, par_q} <= {ovr_d, frm_d, par_d};
        end
    end

    // Snapshot assembled from registered state and the live CTS input; low bits stay zero.
    always_comb begin
        stat_word = `SPS_RST_WORD; // [R18]
        stat_word[`SPS_BIT_RD_ACT] = rda_q;
        stat_word[`SPS_BIT_RD_OK] = rdo_q;
        stat_word[`SPS_BIT_RD_TMO] = rdt_q;
        stat_word[`SPS_BIT_WR_ACT] = wra_q;
        stat_word[`SPS_BIT_WR_OK] = wro_q;
        stat_word[`SPS_BIT_WR_TMO] = wrt_q;
        stat_word[`SPS_BIT_CHARS] = (cnt_q != '0); // [R12]
        stat_word[`SPS_BIT_OVR] = ovr_q;
        stat_word[`SPS_BIT_FRM] = frm_q;
        stat_word[`SPS_BIT_PAR] = par_q;
        stat_word[`SPS_BIT_CTS] = cts_i || !cts_present_i; // [R17]
    end

    ////////////////////////////////////////////////////////////////////////
    // Replies, completion and line control.
    sps_reply_type reply_q, reply_d;
    sps_done_type done_q, done_d;
    logic rts_q, rts_d, drv_q, drv_d, line_q, line_d;
    logic known;

    assign known = do_flush || do_status || do_rts || do_init;

    // Replies are one-cycle pulses; the fields hold until the next one.
    always_comb begin
        reply_d = reply_q;
        reply_d.valid = do_status;
        done_d = done_q;
        done_d.valid = (state_q == ST_EXEC); // [R27]
        rts_d = rts_q;
        if (do_status) begin
            reply_d.status = stat_word; // [R05]
            reply_d.count = 16'(cnt_q); // [R05]
            reply_d.mem_type = cmd_q.word8; // [R04]
            reply_d.mem_off = cmd_q.word9; // [R04]
        end
        if (state_q == ST_EXEC) begin
            done_d.mem_type = cmd_q.stat_type; // [R27]
            done_d.mem_off = cmd_q.stat_off;
            done_d.code = known ? `SPS_DONE_OK : `SPS_DONE_BAD;
        end
        if (do_rts) begin
            // Bits 14..0 are ignored whatever the requester put there.
            rts_d = cmd_q.word8[`SPS_BIT_CTL_RTS]; // [R20] [R21] [R22]
        end else if (do_init) begin
            rts_d = `SPS_RST_RTS; // [R26]
        end
        // The other ports have no driver gating and pass RTS straight out.
        drv_d = !port_is_485_i || (duplex_i == SPS_DPX_PTP) || // [R25]
                tx_sending_i; // [R24]
        line_d = rts_q && drv_d; // [R23]
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reply_q <= '0;
            done_q <= '0;
            rts_q <= `SPS_RST_RTS;
            drv_q <= 1'b0;
            line_q <= 1'b0;
        end else begin
            reply_q <= reply_d;
            done_q <= done_d;
            rts_q <= rts_d;
            drv_q <= drv_d;
            line_q <= line_d;
        end
    end
    assign reply_o = reply_q;
    assign done_o = done_q;
    assign tx_drv_en_o = drv_q;
    assign rts_line_o = line_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_accept;
        cmd_valid_i && ready_q;
    endsequence
    sequence s_exec_done;
        (state_q == ST_EXEC) ##1 (done_q.valid && ready_q);
    endsequence

    a_cmd_complete: assert property (s_accept |=> s_exec_done) // [R27]
        else $error("command not completed in two cycles");
    a_flush_empty: assert property (flush |=> (cnt_q == '0) && // [R02]
        !stat_word[`SPS_BIT_CHARS])
        else $error("flush left characters");
    a_full_drop: assert property (buf_ovr |=> ovr_q && // [R14]
        (cnt_q == $past(cnt_q) - CW'($past(pop))))
        else $error("full buffer accepted a character");
    a_status_pair: assert property (do_status |=> reply_q.valid && // [R05]
        (reply_q.count == 16'($past(cnt_q))) &&
        (reply_q.mem_off == $past(cmd_q.word9)))
        else $error("status reply wrong");
    a_sticky_clr: assert property (do_status && !rx_frame_err_i // [R15]
        |=> !frm_q)
        else $error("frame error not cleared by status");
    a_low_zero: assert property (reply_q.valid |-> // [R18]
        (reply_q.status[4:0] == 5'h00))
        else $error("status low bits not zero");
    a_read_start: assert property (rd_start_i |=> rda_q && !rdo_q // [R06]
        && !rdt_q)
        else $error("read start flags wrong");
    a_read_end: assert property (rd_ok_i && !rd_start_i |=> // [R07]
        !rda_q && rdo_q)
        else $error("read success flags wrong");
    a_write_tmo: assert property (wr_tmo_i && !wr_start_i |=> // [R11]
        !wra_q && wrt_q)
        else $error("write timeout flags wrong");
    a_rts_cmd: assert property (do_rts |=> // [R21]
        (rts_q == $past(cmd_q.word8[15])) ##1 (line_q == (rts_q && drv_q)))
        else $error("commanded rts not applied");
    a_rts_gate: assert property (port_is_485_i && // [R23]
        (duplex_i != SPS_DPX_PTP) && !tx_sending_i |=> !line_q && !drv_q)
        else $error("rts seen with driver off");
endmodule : sps_ctrl

/* tb/sps_peer.sv */
`timescale 1ns/100ps
// Remote serial device feeding characters, line faults and CTS.
module sps_peer (
    // Clock.
    input wire logic mclk_i,
    // Receive side towards the block.
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic [2:0] err_o,
    output logic cts_o
);
    // Idle data is the inverse of the last byte, so no stale copy passes.
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        err_o = 3'h0;
        cts_o = 1'b0;
    end
    ////////////////////////////////////////
    // One character strobe, launched just after a rising edge.
    task send(input logic [7:0] b);
        @(posedge mclk_i);
        #1;
        rx_valid_o = 1'b1;
        rx_data_o = b;
        @(posedge mclk_i);
        #1;
        rx_valid_o = 1'b0;
        rx_data_o = ~b;
    endtask : send
    // One cycle of line faults: overrun, framing, parity.
    task fault(input logic [2:0] e);
        @(posedge mclk_i);
        #1;
        err_o = e;
        @(posedge mclk_i);
        #1;
        err_o = 3'h0;
    endtask : fault
    // CTS is a level held until changed.
    task set_cts(input logic v);
        cts_o = v;
    endtask : set_cts
endmodule : sps_peer

/* tb/serial_port_status_control_test.sv */
`timescale 1ns/100ps
`include "sps_map.svh"
module serial_port_status_control_test import sps_pkg::*;;
    localparam int DEPTH = 4;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    sps_cmd_type cmd_i = '0;
    logic cmd_ready_o;
    sps_reply_type reply_o;
    sps_done_type done_o;
    logic [7:0] evt = 8'h00;
    logic rx_valid;
    logic [7:0] rx_data;
    logic [2:0] rx_err;
    logic rd_take_i = 1'b0;
    logic [7:0] rd_data_o;
    logic rd_data_valid_o;
    logic cts;
    logic cts_present_i = 1'b1;
    logic port_is_485_i = 1'b0;
    sps_dpx_type duplex_i = SPS_DPX_PTP;
    logic tx_sending_i = 1'b0;
    logic tx_drv_en_o;
    logic rts_line_o;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    int k;
    int i;
    sps_reply_type rep;
    logic [7:0] ev [10] = '{8'h80, 8'h40, 8'h80, 8'h20, 8'h88,
        8'h42, 8'h08, 8'h04, 8'h88, 8'h11};
    logic [15:0] es [10] = '{16'h8020, 16'h4020, 16'h8020, 16'h2020,
        16'h9020, 16'h4420, 16'h5020, 16'h4820, 16'h9020, 16'h0020};
    logic [3:0] md [6] = '{4'h0, 4'hA, 4'hB, 4'hC, 4'hD, 4'h8};
    logic [1:0] ex [6] = '{2'h3, 2'h0, 2'h3, 2'h0, 2'h3, 2'h3};

    // Free-running 20 MHz clock.
    always #25 mclk_i = ~mclk_i;

    sps_peer u_peer (.mclk_i(mclk_i), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data), .err_o(rx_err), .cts_o(cts));

    sps_ctrl #(.DEPTH(DEPTH)) u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
        .cmd_ready_o(cmd_ready_o), .reply_o(reply_o), .done_o(done_o),
        .rd_start_i(evt[7]), .rd_ok_i(evt[6]), .rd_tmo_i(evt[5]),
        .rd_cancel_i(evt[4]), .wr_start_i(evt[3]), .wr_ok_i(evt[2]),
        .wr_tmo_i(evt[1]), .wr_cancel_i(evt[0]),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data),
        .rx_overrun_i(rx_err[2]), .rx_frame_err_i(rx_err[1]),
        .rx_parity_err_i(rx_err[0]), .rd_take_i(rd_take_i),
        .rd_data_o(rd_data_o), .rd_data_valid_o(rd_data_valid_o),
        .cts_i(cts), .cts_present_i(cts_present_i),
        .port_is_485_i(port_is_485_i), .duplex_i(duplex_i),
        .tx_sending_i(tx_sending_i), .tx_drv_en_o(tx_drv_en_o),
        .rts_line_o(rts_line_o));

    ////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask : chk

    // A command is held until taken; the answer lands two edges later.
    task cmd(input logic [15:0] c, input logic [15:0] w8);
        @(posedge mclk_i);
        #1;
        cmd_valid_i = 1'b1;
        cmd_i = '{c, w8, 16'h0065, 16'h0008, 16'h0003};
        k = 0;
        while (cmd_ready_o !== 1'b1 && k < 9) begin
            @(posedge mclk_i);
            #1;
            k++;
        end
        @(posedge mclk_i);
        #1;
        cmd_valid_i = 1'b0;
        // The execute edge follows the take edge; the pulse stands after it.
        @(posedge mclk_i);
        #1;
        chk("done_valid", 16'h0001, {15'h0000, done_o.valid});
        rep = reply_o;
    endtask : cmd

    task stat(input logic [15:0] e, input logic [15:0] n);
        cmd(`SPS_CMD_STATUS, 16'h004C);
        chk("reply_valid", 16'h0001, {15'h0000, rep.valid});
        chk("status", e, rep.status);
        chk("count", n, rep.count);
    endtask : stat

    task pulse(input logic [7:0] v);
        @(posedge mclk_i);
        #1;
        evt = v;
        @(posedge mclk_i);
        #1;
        evt = 8'h00;
    endtask : pulse

    // The popped byte is valid one cycle after the take.
    task pop(input logic v, input logic [7:0] d);
        @(posedge mclk_i);
        #1;
        rd_take_i = 1'b1;
        @(posedge mclk_i);
        #1;
        rd_take_i = 1'b0;
        chk("rd_valid", {15'h0000, v}, {15'h0000, rd_data_valid_o});
        if (v) begin
            chk("rd_data", {8'h00, d}, {8'h00, rd_data_o});
        end
    endtask : pop

    // Both line outputs trail their causes, so let them settle first.
    task line(input logic [1:0] e);
        repeat (3) @(posedge mclk_i);
        #1;
        chk("drv_rts", {14'h0000, e}, {14'h0000, tx_drv_en_o, rts_line_o});
    endtask : line

    task tdone(input string n);
        $display("test %s finished", n);
    endtask : tdone

    // A hung handshake cuts the run short here.
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            report_and_stop;
        end
    end

    ////////////////////////////////////////
    // Main sequence of tests.
    initial begin
        repeat (20) @(posedge mclk_i);
        #1;
        chk("ready_rst", 16'h0001, {15'h0000, cmd_ready_o});
        chk("rts_rst", 16'h0000, {15'h0000, rts_line_o});
        nrst_i = 1'b1;
        stat(16'h0000, 16'h0000);
        chk("reply_type", 16'h004C, rep.mem_type);
        chk("reply_off", 16'h0065, rep.mem_off);
        chk("done_type", 16'h0008, done_o.mem_type);
        chk("done_off", 16'h0003, done_o.mem_off);
        chk("done_code", `SPS_DONE_OK, done_o.code);
        cts_present_i = 1'b0;
        stat(16'h0020, 16'h0000);
        cts_present_i = 1'b1;
        u_peer.set_cts(1'b1);
        stat(16'h0020, 16'h0000);
        tdone("reset");
        for (i = 0; i <= DEPTH; i++) begin
            u_peer.send(8'hA0 + i[7:0]);
        end
        stat(16'h0320, 16'(DEPTH));
        stat(16'h0220, 16'(DEPTH));
        pop(1'b1, 8'hA0);
        stat(16'h0220, 16'(DEPTH - 1));
        cmd(`SPS_CMD_FLUSH, 16'h0000);
        stat(16'h0020, 16'h0000);
        pop(1'b0, 8'h00);
        tdone("buffer");
        u_peer.fault(3'h3);
        stat(16'h00E0, 16'h0000);
        stat(16'h0020, 16'h0000);
        u_peer.fault(3'h4);
        stat(16'h0120, 16'h0000);
        tdone("errors");
        for (i = 0; i < 10; i++) begin
            pulse(ev[i]);
            stat(es[i], 16'h0000);
        end
        tdone("events");
        cmd(`SPS_CMD_RTS, 16'h8000);
        for (i = 0; i < 6; i++) begin
            port_is_485_i = md[i][3];
            duplex_i = sps_dpx_type'(md[i][2:1]);
            tx_sending_i = md[i][0];
            line(ex[i]);
        end
        cmd(`SPS_CMD_RTS, 16'h0000);
        line(2'h2);
        cmd(`SPS_CMD_RTS, 16'h8000);
        u_peer.send(8'h55);
        cmd(`SPS_CMD_INIT, 16'h0000);
        line(2'h2);
        stat(16'h0020, 16'h0000);
        cmd(16'h1234, 16'h0000);
        chk("done_bad", `SPS_DONE_BAD, done_o.code);
        tdone("rts");
        report_and_stop;
    end
endmodule : serial_port_status_control_test
